/* gw_cfg.svh */
`ifndef GW_CFG_SVH
`define GW_CFG_SVH
`define GW_ADDR_W 7
`define GW_ADDR_FACTORY 7'h00
`define GW_ADDR_MAX 7'h7D
`define GW_QC_BAD 8'h00
`define GW_QC_A_LO 8'h84
`define GW_QC_A_HI 8'h87
`define GW_QC_B_LO 8'h90
`define GW_QC_B_HI 8'h93
`define GW_QC_BASE 8'h80
`define GW_DELAY_MS 100
`define GW_CLK_HZ 40000000
`define GW_DELAY_CYC ((`GW_DELAY_MS * (`GW_CLK_HZ / 1000)))
`define GW_ERASE_CYC 16
`endif

/* gw_pkg.sv */
package gw_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] qc;
    } io_word_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CONFIG = 3'b001,
        ST_DELAY = 3'b011,
        ST_RUN = 3'b010,
        ST_STANDBY = 3'b110,
        ST_ERASE = 3'b111
    } gw_state_t;
endpackage : gw_pkg

/* gw_qc_map.sv */
`timescale 1ns/1ps
`include "gw_cfg.svh"
module gw_qc_map
    import gw_pkg::*;
(
    input wire logic [7:0] i_qc, // raw input quality code
    output logic [7:0] o_qc // code as delivered to the master
);
    wire in_a = (i_qc >= `GW_QC_A_LO) && (i_qc <= `GW_QC_A_HI);
    wire in_b = (i_qc >= `GW_QC_B_LO) && (i_qc <= `GW_QC_B_HI);
    wire [7:0] mapped = `GW_QC_BASE | {6'h00, i_qc[1:0]};
    assign o_qc = (in_a || in_b) ? mapped : i_qc; // [RL12] [RL13] [RL20]
endmodule : gw_qc_map

/* gw_io_mem.sv */
`timescale 1ns/1ps
`include "gw_cfg.svh"
module gw_io_mem
    import gw_pkg::*;
#(
    parameter int N = 8,
    parameter int AW = 3
) (
    input wire logic i_clk, // clock
    input wire logic i_we, // write strobe
    input wire logic [AW-1:0] i_waddr, // write index
    input wire io_word_t i_wdata, // write word
    input wire logic [AW-1:0] i_raddr, // read index
    output io_word_t o_rdata // registered read word
);
    initial begin
        if ((1 << AW) < N) $error("gw_io_mem: AW too small");
    end
    io_word_t mem_q [N];
    always_ff @(posedge i_clk) begin
        if (i_we) mem_q[i_waddr] <= i_wdata;
        o_rdata <= mem_q[i_raddr];
    end
endmodule : gw_io_mem

/* gw_gateway.sv */
`timescale 1ns/1ps
`include "gw_cfg.svh"
// What this block does
// RL1: start needs valid address, master, configuration
// RL2: each master configures its own module
// RL3: module on master processor side goes active
// RL4: standby only after own configuration complete
// RL5: standby passive, takes over on partner fail
// RL6: startup zeroes all data, quality bad
// RL7: identified devices forward outputs and inputs
// RL8: outputs held zero during startup delay
// RL9: failed device data and quality cleared
// RL10: master failure clears outputs and quality
// RL11: run state passes outputs unchanged
// RL12: input quality 0x84-0x87 becomes 0x80-0x83
// RL13: input quality 0x90-0x93 becomes 0x80-0x83
// RL14: restore default erases store, stops cyclic
// RL15: address zero at power-up restores factory
// RL16: replacement takes parameters from running partner
// RL17: active removed, partner switches over
// RL18: smooth switchover needs healthy passive indicators
// RL19: mismatch waits delay, enables good, reports others
// RL20: other quality codes pass unchanged
module gw_gateway
    import gw_pkg::*;
#(
    parameter int N_DEV = 8,
    parameter int AW = 3,
    parameter int DELAY_CYC = `GW_DELAY_CYC
) (
    input wire logic i_clk, // 40 MHz clock
    input wire logic i_reset_n, // synchronous reset, active low
    input wire logic [`GW_ADDR_W-1:0] i_bus_addr, // address switch pins
    input wire logic i_master_run, // own master operating and in run
    input wire logic i_config_ok, // own master finished configuration
    input wire logic i_redundant, // redundancy mode strap
    input wire logic i_master_cpu_side, // attached to master processor subsystem
    input wire logic i_partner_alive, // partner module running
    input wire logic i_partner_active, // partner is the active module
    input wire logic i_partner_params, // partner offers its parameters
    input wire logic i_restore_cmd, // restore-default command pulse
    input wire logic [N_DEV-1:0] i_dev_ident, // device identified with right name and address
    input wire logic i_out_we, // master writes one device output
    input wire logic [AW-1:0] i_out_idx, // device index of master write
    input wire io_word_t i_out_word, // output word from master
    input wire logic i_in_we, // field delivers one device input
    input wire logic [AW-1:0] i_in_idx, // device index of field input
    input wire io_word_t i_in_word, // input word from field
    input wire logic [AW-1:0] i_rd_idx, // device polled on both sides
    output io_word_t o_field_out, // output word to field device
    output io_word_t o_master_in, // input word to master
    output logic o_cyclic_en, // cyclic fieldbus traffic running
    output logic o_active_unit_indicator, // this module is active
    output logic o_bus_fault_indicator, // bus fault lamp
    output logic o_group_error_indicator, // group error lamp
    output logic o_nv_erase, // erase parameter store, level
    output logic o_partner_reset, // reset request to partner
    output logic o_param_copy, // pull parameters from partner
    output logic [N_DEV-1:0] o_dev_alarm // removal or diagnostic report per device
);
    initial begin
        if (N_DEV < 1 || (1 << AW) < N_DEV) $error("gw_gateway: bad N_DEV/AW");
        if (DELAY_CYC < 1) $error("gw_gateway: DELAY_CYC must be positive");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // synchronisers for pins
    logic [`GW_ADDR_W-1:0] addr_s1_q, addr_q;
    logic [10:0] ctl_s1_q, ctl_q;
    logic [N_DEV-1:0] ident_s1_q, ident_q;
    wire [10:0] ctl_raw = {i_master_run, i_config_ok, i_redundant, i_master_cpu_side,
                           i_partner_alive, i_partner_active, i_partner_params, i_restore_cmd,
                           3'b000};
    always_ff @(posedge i_clk) begin
        addr_s1_q <= i_bus_addr;
        addr_q <= addr_s1_q;
        ctl_s1_q <= ctl_raw;
        ctl_q <= ctl_s1_q;
        ident_s1_q <= i_dev_ident;
        ident_q <= ident_s1_q;
    end
    wire master_run = ctl_q[10];
    wire config_ok = ctl_q[9];
    wire redundant = ctl_q[8];
    wire cpu_side = ctl_q[7];
    wire partner_alive = ctl_q[6];
    wire partner_active = ctl_q[5];
    wire partner_params = ctl_q[4];
    wire restore_lvl = ctl_q[3];

    ////////////////////////////////////////////////////////////////////////////////
    // power-up strap capture and restore edge
    logic boot_done_q, factory_q, restore_d1_q;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            boot_done_q <= 1'b0;
            factory_q <= 1'b0;
            restore_d1_q <= 1'b0;
        end else begin
            restore_d1_q <= restore_lvl;
            if (!boot_done_q) begin
                boot_done_q <= 1'b1;
                factory_q <= (addr_q == `GW_ADDR_FACTORY); // [RL15]
            end
        end
    end
    wire restore_evt = restore_lvl && !restore_d1_q;
    wire addr_valid = (addr_q != `GW_ADDR_FACTORY) && (addr_q <= `GW_ADDR_MAX);
    wire start_ok = addr_valid && master_run && config_ok; // [RL1]

    ////////////////////////////////////////////////////////////////////////////////
    // state machine
    gw_state_t state_q, state_d;
    logic [31:0] cnt_q, cnt_d;
    logic had_params_q;
    wire delay_done = (cnt_q >= 32'(DELAY_CYC - 1));
    wire erase_done = (cnt_q >= 32'(`GW_ERASE_CYC - 1));
    // the cpu-side module wins; otherwise it waits behind a live active partner
    wire go_active = !redundant || cpu_side || !(partner_alive && partner_active); // [RL3]
    wire need_erase = restore_evt || (boot_done_q && factory_q && state_q == ST_IDLE);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 32'd1;
        if (need_erase && state_q != ST_ERASE) begin
            state_d = ST_ERASE; // [RL14] [RL15]
            cnt_d = 32'd0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    cnt_d = 32'd0;
                    if (boot_done_q && start_ok) state_d = ST_CONFIG; // [RL1]
                end
                ST_CONFIG: begin
                    cnt_d = 32'd0;
                    if (!start_ok) state_d = ST_IDLE;
                    else if (go_active) state_d = ST_DELAY; // [RL3]
                    else state_d = ST_STANDBY; // [RL4]
                end
                ST_DELAY: begin
                    if (!start_ok) state_d = ST_IDLE; // [RL10]
                    else if (delay_done) state_d = ST_RUN; // [RL19]
                end
                ST_RUN: begin
                    cnt_d = cnt_q;
                    if (!start_ok) state_d = ST_IDLE; // [RL10]
                end
                ST_STANDBY: begin
                    cnt_d = 32'd0;
                    if (!start_ok) state_d = ST_IDLE;
                    else if (!partner_alive || !partner_active) state_d = ST_RUN; // [RL5] [RL17]
                end
                ST_ERASE: begin
                    if (erase_done && !factory_q) state_d = ST_IDLE;
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 32'd0;
            had_params_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (state_q == ST_ERASE) had_params_q <= 1'b0;
            else if (config_ok) had_params_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // process image: clear sweep, master writes, field writes
    wire active = (state_q == ST_RUN) || (state_q == ST_DELAY);
    wire running = (state_q == ST_RUN);
    wire clearing = !active; // image held at zero whenever not active
    logic [AW-1:0] sweep_q;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) sweep_q <= '0;
        else if (sweep_q == AW'(N_DEV - 1)) sweep_q <= '0;
        else sweep_q <= sweep_q + AW'(1);
    end
    // a failed device is cleared by the sweep; field writes to it are dropped
    wire sweep_dev_bad = !ident_q[sweep_q];
    wire out_wr_ok = i_out_we && running && ident_q[i_out_idx];
    wire in_wr_ok = i_in_we && active && ident_q[i_in_idx];
    wire out_clr = clearing || sweep_dev_bad; // [RL6] [RL9] [RL10]
    wire in_clr = clearing || sweep_dev_bad; // [RL6] [RL9]
    wire out_we = out_wr_ok || out_clr;
    wire in_we = in_wr_ok || in_clr;
    wire [AW-1:0] out_wa = out_wr_ok ? i_out_idx : sweep_q;
    wire [AW-1:0] in_wa = in_wr_ok ? i_in_idx : sweep_q;
    wire io_word_t zero_word = '{data: 8'h00, qc: `GW_QC_BAD};
    wire io_word_t out_wd = out_wr_ok ? i_out_word : zero_word; // [RL11]
    wire io_word_t in_wd = in_wr_ok ? i_in_word : zero_word;

    io_word_t out_rd, in_rd;
    gw_io_mem #(.N(N_DEV), .AW(AW)) u_out_mem (
        .i_clk(i_clk),
        .i_we(out_we),
        .i_waddr(out_wa),
        .i_wdata(out_wd),
        .i_raddr(i_rd_idx),
        .o_rdata(out_rd)
    );
    gw_io_mem #(.N(N_DEV), .AW(AW)) u_in_mem (
        .i_clk(i_clk),
        .i_we(in_we),
        .i_waddr(in_wa),
        .i_wdata(in_wd),
        .i_raddr(i_rd_idx),
        .o_rdata(in_rd)
    );

    logic [7:0] qc_mapped;
    gw_qc_map u_qc_map (
        .i_qc(in_rd.qc),
        .o_qc(qc_mapped)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, registered
    logic [AW-1:0] rd_idx_q;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rd_idx_q <= '0;
            o_field_out <= '0;
            o_master_in <= '0;
            o_cyclic_en <= 1'b0;
            o_active_unit_indicator <= 1'b0;
            o_bus_fault_indicator <= 1'b0;
            o_group_error_indicator <= 1'b0;
            o_nv_erase <= 1'b0;
            o_partner_reset <= 1'b0;
            o_param_copy <= 1'b0;
            o_dev_alarm <= '0;
        end else begin
            rd_idx_q <= i_rd_idx;
            // zero during the delay and for unidentified devices
            o_field_out <= (running && ident_q[rd_idx_q]) ? out_rd : '0; // [RL7] [RL8] [RL11]
            o_master_in <= active ? '{data: in_rd.data, qc: qc_mapped} : '0; // [RL7] [RL12] [RL13]
            o_cyclic_en <= active; // [RL14]
            o_active_unit_indicator <= active; // [RL3] [RL5]
            o_bus_fault_indicator <= !master_run || (active && (ident_q != '1));
            // steady group error means this module is not fit to take over
            o_group_error_indicator <= !addr_valid || (redundant && !config_ok); // [RL18]
            o_nv_erase <= (state_q == ST_ERASE); // [RL14]
            o_partner_reset <= (state_q == ST_ERASE) && redundant && !factory_q; // [RL14]
            o_param_copy <= redundant && !had_params_q && partner_alive && partner_params; // [RL16]
            o_dev_alarm <= running ? ~ident_q : '0; // [RL19]
        end
    end
endmodule : gw_gateway

/* gw_gateway_asserts.sv */
`timescale 1ns/1ps
`include "gw_cfg.svh"
module gw_gateway_asserts import gw_pkg::*; #(parameter int N_DEV = 8) (
    input wire logic i_clk, // clock
    input wire logic i_reset_n, // reset
    input wire logic [`GW_ADDR_W-1:0] i_bus_addr, // address
    input wire logic i_master_run, // master up
    input wire logic i_redundant, // mode
    input wire io_word_t o_field_out, // to field
    input wire io_word_t o_master_in, // to master
    input wire logic o_cyclic_en, // cyclic
    input wire logic o_group_error_indicator, // lamp
    input wire logic o_nv_erase, // erase
    input wire logic o_partner_reset, // partner reset
    input wire logic [N_DEV-1:0] o_dev_alarm // alarms
);
    // sync lag plus a full sweep before a lost master must show
    localparam int LOSS = N_DEV + 6;
    logic [7:0] loss_q;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || i_master_run) begin
            loss_q <= 8'h00;
        end else if (loss_q != 8'hFF) begin
            loss_q <= loss_q + 8'h01;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    property p_rst_zero; $rose(i_reset_n) |-> o_field_out == 16'h0000 && !o_cyclic_en; endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("outputs not clear after reset");
    property p_erase; o_nv_erase |-> !o_cyclic_en; endproperty
    a_erase: assert property (p_erase) else $error("cyclic traffic during erase");
    property p_prst; o_partner_reset |-> o_nv_erase && i_redundant; endproperty
    a_prst: assert property (p_prst) else $error("partner reset outside redundant erase");
    property p_alarm; o_dev_alarm != '0 |-> o_cyclic_en; endproperty
    a_alarm: assert property (p_alarm) else $error("device alarm while not active");
    property p_qc_a; !(o_master_in.qc inside {[8'h84:8'h87]}); endproperty
    a_qc_a: assert property (p_qc_a) else $error("quality code not remapped, low range");
    property p_qc_b; !(o_master_in.qc inside {[8'h90:8'h93]}); endproperty
    a_qc_b: assert property (p_qc_b) else $error("quality code not remapped, high range");
    property p_bad_addr; (i_bus_addr > `GW_ADDR_MAX)[*4] |-> o_group_error_indicator && !o_cyclic_en; endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("invalid address not refused");
    property p_loss; loss_q >= LOSS |-> o_field_out == 16'h0000 && !o_cyclic_en; endproperty
    a_loss: assert property (p_loss) else $error("outputs kept after master loss");
    cover property (o_cyclic_en && o_field_out != 16'h0000);
    cover property (o_partner_reset);
    cover property (o_dev_alarm != '0);
endmodule : gw_gateway_asserts
bind gw_gateway gw_gateway_asserts #(.N_DEV(N_DEV)) gw_gateway_asserts_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_bus_addr(i_bus_addr), .i_master_run(i_master_run), .i_redundant(i_redundant), .o_field_out(o_field_out),
    .o_master_in(o_master_in), .o_cyclic_en(o_cyclic_en), .o_group_error_indicator(o_group_error_indicator),
    .o_nv_erase(o_nv_erase), .o_partner_reset(o_partner_reset), .o_dev_alarm(o_dev_alarm));

/* gw_master_model.sv */
`timescale 1ns/1ps
module gw_master_model import gw_pkg::*; #(parameter int CFG_CYC = 4) (
    input wire logic i_clk, // clock
    input wire logic i_go, // master in run
    input wire logic i_wr, // write request
    input wire logic [2:0] i_idx, // target device
    input wire io_word_t i_word, // output word
    output logic o_master_run, // to gateway
    output logic o_config_ok, // to gateway
    output logic o_out_we, // to gateway
    output logic [2:0] o_out_idx, // to gateway
    output io_word_t o_out_word // to gateway
);
    int cnt_q = 0;
    initial begin
        o_master_run = 1'b0;
        o_config_ok = 1'b0;
        o_out_we = 1'b0;
        o_out_idx = 3'h0;
        o_out_word = 16'h0000;
    end
    always @(posedge i_clk) begin
        o_master_run <= i_go;
        cnt_q <= i_go ? cnt_q + 1 : 0;
        o_config_ok <= i_go && cnt_q >= CFG_CYC;
        o_out_we <= i_wr && i_go;
        // an idle bus toggles so stale words are never mistaken for data
        o_out_idx <= i_wr ? i_idx : ~o_out_idx;
        o_out_word <= i_wr ? i_word : ~o_out_word;
    end
endmodule : gw_master_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
    import gw_pkg::*;
    localparam int DLY = 20;
    logic i_clk, i_reset_n, go, wr, red, cpu, p_alive, p_act, p_par, rst_cmd, in_we;
    logic mrun, cfg_ok, out_we, cyc, act, bf, ge, ers, prst, pcopy;
    logic [6:0] addr;
    logic [7:0] ident, alarm;
    logic [2:0] idx, in_idx, rd_idx, out_idx;
    io_word_t wword, in_word, out_word, f_out, m_in;
    int n_fail = 0;
    int n_tests = 0;
    int n_cyc = 0;
    gw_gateway #(.DELAY_CYC(DLY)) gw_gateway_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus_addr(addr),
        .i_master_run(mrun), .i_config_ok(cfg_ok), .i_redundant(red), .i_master_cpu_side(cpu),
        .i_partner_alive(p_alive), .i_partner_active(p_act), .i_partner_params(p_par), .i_restore_cmd(rst_cmd),
        .i_dev_ident(ident), .i_out_we(out_we), .i_out_idx(out_idx), .i_out_word(out_word), .i_in_we(in_we),
        .i_in_idx(in_idx), .i_in_word(in_word), .i_rd_idx(rd_idx), .o_field_out(f_out), .o_master_in(m_in),
        .o_cyclic_en(cyc), .o_active_unit_indicator(act), .o_bus_fault_indicator(bf),
        .o_group_error_indicator(ge), .o_nv_erase(ers), .o_partner_reset(prst), .o_param_copy(pcopy),
        .o_dev_alarm(alarm));
    gw_master_model gw_master_model_i (.i_clk(i_clk), .i_go(go), .i_wr(wr), .i_idx(idx), .i_word(wword),
        .o_master_run(mrun), .o_config_ok(cfg_ok), .o_out_we(out_we), .o_out_idx(out_idx), .o_out_word(out_word));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask : step
    task automatic wait_cyc(input logic v);
        for (int k = 0; k < 300 && cyc !== v; k++) step(1);
    endtask : wait_cyc
    task automatic do_reset(input logic [6:0] a);
        i_reset_n = 1'b0;
        addr = a;
        go = 1'b0;
        step(4);
        i_reset_n = 1'b1;
    endtask : do_reset
    task automatic m_write(input logic [2:0] i, input logic [15:0] w);
        wr = 1'b1;
        idx = i;
        wword = w;
        rd_idx = i;
        step(1);
        wr = 1'b0;
        step(6);
    endtask : m_write
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_boot();
        do_reset(7'h7F);
        go = 1'b1;
        step(40);
        chk("bad_addr", 16'h0000, {15'h0000, cyc});
        chk("bad_addr_ge", 16'h0001, {15'h0000, ge});
        do_reset(7'h00);
        step(40);
        chk("factory", 16'h0001, {15'h0000, ers});
    endtask : t_boot
    task automatic t_start();
        do_reset(7'h05);
        go = 1'b1;
        wait_cyc(1'b1);
        chk("active", 16'h0001, {15'h0000, act});
        m_write(3'h2, 16'h5A84);
        chk("delay_out", 16'h0000, f_out);
        step(DLY);
        m_write(3'h2, 16'h5A84);
        chk("run_out", 16'h5A84, f_out);
    endtask : t_start
    task automatic t_qc();
        logic [7:0] q [7] = '{8'h84, 8'h87, 8'h90, 8'h93, 8'h83, 8'h88, 8'h94};
        logic [7:0] e;
        for (int k = 0; k < 7; k++) begin
            e = (q[k] inside {[8'h84:8'h87], [8'h90:8'h93]}) ? (8'h80 | {6'h00, q[k][1:0]}) : q[k];
            in_we = 1'b1;
            in_idx = 3'h2;
            in_word = {8'h3C, q[k]};
            step(1);
            in_we = 1'b0;
            in_word = ~in_word;
            step(6);
            chk("qc", {8'h3C, e}, m_in);
        end
    endtask : t_qc
    task automatic t_fail();
        ident = 8'hFB;
        step(16);
        chk("fail_out", 16'h0000, f_out);
        chk("fail_in", 16'h0000, m_in);
        chk("alarm", 16'h0004, {8'h00, alarm});
        chk("bus_fault", 16'h0001, {15'h0000, bf});
        ident = 8'hFF;
        m_write(3'h6, 16'h1234);
        go = 1'b0;
        step(20);
        chk("mfail_out", 16'h0000, f_out);
    endtask : t_fail
    task automatic t_standby();
        red = 1'b1;
        cpu = 1'b0;
        p_act = 1'b1;
        do_reset(7'h05);
        go = 1'b1;
        step(2);
        chk("pcopy", 16'h0001, {15'h0000, pcopy});
        step(38);
        chk("standby", 16'h0000, {14'h0000, cyc, pcopy});
        p_alive = 1'b0;
        wait_cyc(1'b1);
        chk("takeover", 16'h0001, {15'h0000, cyc});
        rst_cmd = 1'b1;
        step(3);
        rst_cmd = 1'b0;
        step(4);
        chk("erase", 16'h0003, {13'h0000, cyc, ers, prst});
    endtask : t_standby
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        n_cyc++;
        if (n_cyc > 5000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        {i_reset_n, go, wr, red, p_act, rst_cmd, in_we} = 7'h00;
        {cpu, p_alive, p_par} = 3'h7;
        {addr, ident, idx, in_idx, rd_idx} = 24'h0;
        {wword, in_word} = 32'h0;
        t_boot();
        ident = 8'hFF;
        t_start();
        t_qc();
        t_fail();
        t_standby();
        report_and_stop();
    end
endmodule : tb
